// ===== design/iosp_map.vh
// iosp_map.vh: address map and field constants of the low i/o register bank
// assumes: included by iosp_regbank.v only; definitions only
`ifndef IOSP_MAP_VH
`define IOSP_MAP_VH

// ----------------------------------------
// address windows
// ----------------------------------------
`define IOSP_IO_LAST 8'h3F
`define IOSP_BIT_LAST 8'h1F
`define IOSP_DS_OFFSET 8'h20
`define IOSP_EXT_FIRST 8'h60
`define IOSP_EXT_LAST 8'hFF

// ----------------------------------------
// port block layout
// ----------------------------------------
`define IOSP_PORT_A_IN 8'h00
`define IOSP_PORT_A_DIR 8'h01
`define IOSP_PORT_A_OUT 8'h02
`define IOSP_PORT_B_IN 8'h03
`define IOSP_PORT_B_DIR 8'h04
`define IOSP_PORT_B_OUT 8'h05
`define IOSP_PORT_C_IN 8'h06
`define IOSP_PORT_C_DIR 8'h07
`define IOSP_PORT_C_OUT 8'h08
`define IOSP_PORT_D_IN 8'h09
`define IOSP_PORT_D_DIR 8'h0A
`define IOSP_PORT_D_OUT 8'h0B
`define IOSP_PORT_E_IN 8'h0C
`define IOSP_PORT_E_DIR 8'h0D
`define IOSP_PORT_E_OUT 8'h0E
`define IOSP_PORT_F_IN 8'h0F
`define IOSP_PORT_F_DIR 8'h10
`define IOSP_PORT_F_OUT 8'h11
`define IOSP_FLAG_IO 8'h12
`define IOSP_NUM_PORTS 6
`define IOSP_REGS_PER_PORT 3
`define IOSP_SEL_IN 2'h0
`define IOSP_SEL_DIR 2'h1
`define IOSP_SEL_OUT 2'h2

// ----------------------------------------
// access kinds on the core port
// ----------------------------------------
`define IOSP_OP_NONE 3'h0
`define IOSP_OP_PORT_RD 3'h1
`define IOSP_OP_PORT_WR 3'h2
`define IOSP_OP_MEM_RD 3'h3
`define IOSP_OP_MEM_WR 3'h4
`define IOSP_OP_BIT_SET 3'h5
`define IOSP_OP_BIT_CLR 3'h6
`define IOSP_OP_BIT_TST 3'h7

// ----------------------------------------
// reset values
// ----------------------------------------
`define IOSP_DIR_RST 8'h00
`define IOSP_OUT_RST 8'h00
`define IOSP_FLAG_RST 8'h00

`endif

// ===== design/iosp_regbank.v
// iosp_regbank.v: low i/o register space seen by the processor core
// assumes: core drives one access per cycle on sys_clk_i; pins are asynchronous
// assumes: status flags at io 0x12 are a local choice; unmapped reads give zero
`timescale 1ns/100ps
`default_nettype none
`include "iosp_map.vh"

module iosp_regbank (
   input wire sys_clk_i,
   input wire srst_i,
   input wire [2:0] op_i,
   input wire [7:0] addr_i,
   input wire [2:0] bit_sel_i,
   input wire [7:0] wdata_i,
   output reg [7:0] rdata_o,
   output reg rvalid_o,
   output reg test_bit_o,
   output reg test_valid_o,
   output reg bad_access_o,
   output wire ext_sel_o,
   output wire ext_wr_o,
   output wire [7:0] ext_addr_o,
   output wire [7:0] ext_wdata_o,
   input wire [7:0] ext_rdata_i,
   input wire [7:0] flag_set_i,
   output wire [7:0] flag_o,
   input wire [47:0] pin_in_i,
   output wire [47:0] pin_out_o,
   output wire [47:0] pin_oe_o
);

   // ----------------------------------------
   // access kind decode
   // ----------------------------------------
   // one strobe per access kind keeps the later terms readable
   wire is_port_rd;
   wire is_port_wr;
   wire is_mem_rd;
   wire is_mem_wr;
   wire is_bit_set;
   wire is_bit_clr;
   wire is_bit_tst;

   assign is_port_rd = (op_i == `IOSP_OP_PORT_RD);
   assign is_port_wr = (op_i == `IOSP_OP_PORT_WR);
   assign is_mem_rd = (op_i == `IOSP_OP_MEM_RD);
   assign is_mem_wr = (op_i == `IOSP_OP_MEM_WR);
   assign is_bit_set = (op_i == `IOSP_OP_BIT_SET);
   assign is_bit_clr = (op_i == `IOSP_OP_BIT_CLR);
   assign is_bit_tst = (op_i == `IOSP_OP_BIT_TST);

   // ----------------------------------------
   // address normalisation
   // ----------------------------------------
   wire is_port_op;
   wire is_mem_op;
   wire is_bit_op;
   wire [7:0] io_addr;
   wire io_hit;
   wire ext_hit;
   wire in_ports;
   wire in_flag;
   wire bit_ok;
   wire [7:0] flag_addr;
   reg [2:0] port_idx;
   reg [1:0] reg_sel;

   assign is_port_op = is_port_rd || is_port_wr;
   assign is_mem_op = is_mem_rd || is_mem_wr;
   assign is_bit_op = is_bit_set || is_bit_clr || is_bit_tst;
   // memory forms see the i/o space shifted up by 0x20
   assign io_addr = is_mem_op ? (addr_i - `IOSP_DS_OFFSET) : addr_i;
   assign io_hit = (is_port_op && (addr_i <= `IOSP_IO_LAST)) ||
                   (is_mem_op && (addr_i >= `IOSP_DS_OFFSET) &&
                    (addr_i < `IOSP_EXT_FIRST)) ||
                   (is_bit_op && (addr_i <= `IOSP_BIT_LAST));
   // extended area is handed out only for memory forms
   assign ext_hit = is_mem_op && (addr_i >= `IOSP_EXT_FIRST);
   assign in_ports = io_hit && (io_addr <= `IOSP_PORT_F_OUT);
   // flag register sits right after the port block
   assign flag_addr = `IOSP_FLAG_IO;
   assign in_flag = io_hit && (io_addr == flag_addr);
   assign bit_ok = is_bit_op && io_hit;

   // split io address into port number and register within port
   // an explicit table, so a reordered map cannot slip by an offset
   always @* begin
      port_idx = 3'h0;
      reg_sel = `IOSP_SEL_IN;
      if (io_addr == `IOSP_PORT_A_IN) begin
         port_idx = 3'h0;
         reg_sel = `IOSP_SEL_IN;
      end else if (io_addr == `IOSP_PORT_A_DIR) begin
         port_idx = 3'h0;
         reg_sel = `IOSP_SEL_DIR;
      end else if (io_addr == `IOSP_PORT_A_OUT) begin
         port_idx = 3'h0;
         reg_sel = `IOSP_SEL_OUT;
      end else if (io_addr == `IOSP_PORT_B_IN) begin
         port_idx = 3'h1;
         reg_sel = `IOSP_SEL_IN;
      end else if (io_addr == `IOSP_PORT_B_DIR) begin
         port_idx = 3'h1;
         reg_sel = `IOSP_SEL_DIR;
      end else if (io_addr == `IOSP_PORT_B_OUT) begin
         port_idx = 3'h1;
         reg_sel = `IOSP_SEL_OUT;
      end else if (io_addr == `IOSP_PORT_C_IN) begin
         port_idx = 3'h2;
         reg_sel = `IOSP_SEL_IN;
      end else if (io_addr == `IOSP_PORT_C_DIR) begin
         port_idx = 3'h2;
         reg_sel = `IOSP_SEL_DIR;
      end else if (io_addr == `IOSP_PORT_C_OUT) begin
         port_idx = 3'h2;
         reg_sel = `IOSP_SEL_OUT;
      end else if (io_addr == `IOSP_PORT_D_IN) begin
         port_idx = 3'h3;
         reg_sel = `IOSP_SEL_IN;
      end else if (io_addr == `IOSP_PORT_D_DIR) begin
         port_idx = 3'h3;
         reg_sel = `IOSP_SEL_DIR;
      end else if (io_addr == `IOSP_PORT_D_OUT) begin
         port_idx = 3'h3;
         reg_sel = `IOSP_SEL_OUT;
      end else if (io_addr == `IOSP_PORT_E_IN) begin
         port_idx = 3'h4;
         reg_sel = `IOSP_SEL_IN;
      end else if (io_addr == `IOSP_PORT_E_DIR) begin
         port_idx = 3'h4;
         reg_sel = `IOSP_SEL_DIR;
      end else if (io_addr == `IOSP_PORT_E_OUT) begin
         port_idx = 3'h4;
         reg_sel = `IOSP_SEL_OUT;
      end else if (io_addr == `IOSP_PORT_F_IN) begin
         port_idx = 3'h5;
         reg_sel = `IOSP_SEL_IN;
      end else if (io_addr == `IOSP_PORT_F_DIR) begin
         port_idx = 3'h5;
         reg_sel = `IOSP_SEL_DIR;
      end else if (io_addr == `IOSP_PORT_F_OUT) begin
         port_idx = 3'h5;
         reg_sel = `IOSP_SEL_OUT;
      end
   end

   // ----------------------------------------
   // write data shaping
   // ----------------------------------------
   // bit ops build a one-hot mask so only the addressed bit moves
   wire [7:0] bit_mask;
   wire do_write;
   wire do_set;
   wire do_clr;
   genvar k;

   // one decoder output per bit position
   generate
      for (k = 0; k < 8; k = k + 1) begin : g_mask
         assign bit_mask[k] = (bit_sel_i == k);
      end
   endgenerate
   assign do_write = is_port_wr || is_mem_wr;
   assign do_set = is_bit_set && bit_ok;
   assign do_clr = is_bit_clr && bit_ok;

   // ----------------------------------------
   // per-port registers and pin synchronisers
   // ----------------------------------------
   wire [47:0] dir_all;
   wire [47:0] out_all;
   wire [47:0] in_all;

   genvar g;
   generate
      for (g = 0; g < `IOSP_NUM_PORTS; g = g + 1) begin : g_port
         reg [7:0] dir_r;
         reg [7:0] out_r;
         reg [7:0] meta_r;
         reg [7:0] sync_r;
         wire hit_dir;
         wire hit_out;
         assign hit_dir = in_ports && (port_idx == g) && (reg_sel == `IOSP_SEL_DIR);
         assign hit_out = in_ports && (port_idx == g) && (reg_sel == `IOSP_SEL_OUT);

         // no reset here: reads settle two edges after release
         // two-stage sync; only sync_r is ever read
         always @(posedge sys_clk_i) begin
            meta_r <= pin_in_i[g*8 +: 8];
            sync_r <= meta_r;
         end

         // direction register; a bit op merges its single bit only
         always @(posedge sys_clk_i) begin
            if (srst_i) begin
               dir_r <= `IOSP_DIR_RST;
            end else if (hit_dir && do_write) begin
               dir_r <= wdata_i;
            end else if (hit_dir && do_set) begin
               dir_r <= dir_r | bit_mask;
            end else if (hit_dir && do_clr) begin
               dir_r <= dir_r & ~bit_mask;
            end
         end

         // output latch; same merge rule as the direction register
         always @(posedge sys_clk_i) begin
            if (srst_i) begin
               out_r <= `IOSP_OUT_RST;
            end else if (hit_out && do_write) begin
               out_r <= wdata_i;
            end else if (hit_out && do_set) begin
               out_r <= out_r | bit_mask;
            end else if (hit_out && do_clr) begin
               out_r <= out_r & ~bit_mask;
            end
         end

         assign dir_all[g*8 +: 8] = dir_r;
         assign out_all[g*8 +: 8] = out_r;
         assign in_all[g*8 +: 8] = sync_r;
      end
   endgenerate

   // pin drive follows direction bits
   assign pin_out_o = out_all;
   assign pin_oe_o = dir_all;

   // ----------------------------------------
   // write-one-to-clear status flags
   // ----------------------------------------
   reg [7:0] flag_r;
   reg [7:0] flag_nxt;
   // a full write clears by mask and a bit-set op clears its bit; a bit-clear op is a no-op here
   // limitation: flags are set only by the hardware pulses on flag_set_i
   // a bit op touches just its bit, so other pending flags survive
   always @* begin
      flag_nxt = flag_r;
      if (in_flag && do_write) begin
         flag_nxt = flag_r & ~wdata_i;
      end else if (in_flag && do_clr) begin
         flag_nxt = flag_r; // clearing a w1c bit to zero is a no-op
      end else if (in_flag && do_set) begin
         flag_nxt = flag_r & ~bit_mask;
      end
      // hardware set wins over a same-cycle clear
      flag_nxt = flag_nxt | flag_set_i;
   end

   always @(posedge sys_clk_i) begin
      if (srst_i) begin
         flag_r <= `IOSP_FLAG_RST;
      end else begin
         flag_r <= flag_nxt;
      end
   end
   assign flag_o = flag_r;

   // ----------------------------------------
   // extended area pass-through
   // ----------------------------------------
   // far side answers in the same cycle; its data is registered here
   assign ext_sel_o = ext_hit;
   assign ext_wr_o = ext_hit && (op_i == `IOSP_OP_MEM_WR);
   assign ext_addr_o = addr_i;
   assign ext_wdata_o = wdata_i;

   // ----------------------------------------
   // read mux
   // ----------------------------------------
   // per-port words picked once, then the register kind chooses
   wire [7:0] sel_in;
   wire [7:0] sel_dir;
   wire [7:0] sel_out;
   assign sel_in = in_all[port_idx*8 +: 8];
   assign sel_dir = dir_all[port_idx*8 +: 8];
   assign sel_out = out_all[port_idx*8 +: 8];

   reg [7:0] rd_val;
   always @* begin
      rd_val = 8'h00;
      if (in_ports) begin
         if (reg_sel == `IOSP_SEL_IN) begin
            rd_val = sel_in;
         end else if (reg_sel == `IOSP_SEL_DIR) begin
            rd_val = sel_dir;
         end else begin
            rd_val = sel_out;
         end
      end else if (in_flag) begin
         rd_val = flag_r;
      end else if (ext_hit) begin
         rd_val = ext_rdata_i;
      end
   end

   // ----------------------------------------
   // answer next values
   // ----------------------------------------
   reg [7:0] rdata_nxt;
   reg rvalid_nxt;
   reg test_bit_nxt;
   reg test_valid_nxt;
   reg bad_nxt;

   // a refused bit test still answers, with the bit forced low
   always @* begin
      rvalid_nxt = is_port_rd || is_mem_rd;
      rdata_nxt = rd_val;
      test_valid_nxt = is_bit_tst;
      test_bit_nxt = is_bit_tst && bit_ok && rd_val[bit_sel_i];
      // out-of-window requests are flagged, not performed
      bad_nxt = (op_i != `IOSP_OP_NONE) && !io_hit && !ext_hit;
   end

   // registered answers, one cycle after the request
   always @(posedge sys_clk_i) begin
      if (srst_i) begin
         rdata_o <= 8'h00;
         rvalid_o <= 1'b0;
         test_bit_o <= 1'b0;
         test_valid_o <= 1'b0;
         bad_access_o <= 1'b0;
      end else begin
         rvalid_o <= rvalid_nxt;
         rdata_o <= rdata_nxt;
         test_valid_o <= test_valid_nxt;
         test_bit_o <= test_bit_nxt;
         bad_access_o <= bad_nxt;
      end
   end

endmodule // iosp_regbank
`default_nettype wire

// ===== verification/iosp_ext_model.sv
// iosp_ext_model.sv: extended i/o space behind the bank
// assumes: fed by the bank's ext outputs on one clock
`timescale 1ns/100ps
`default_nettype none
module iosp_ext_model (
   input wire logic sys_clk_i,
   input wire logic sel_i,
   input wire logic wr_i,
   input wire logic [7:0] addr_i,
   input wire logic [7:0] wdata_i,
   output logic [7:0] rdata_o
);
   logic [7:0] mem [256];
   // unselected bus shows a moving pattern, never stale data
   assign rdata_o = sel_i ? mem[addr_i] : ~addr_i;
   always @(posedge sys_clk_i) if (sel_i && wr_i) mem[addr_i] <= wdata_i;
endmodule // iosp_ext_model
`default_nettype wire

// ===== verification/iosp_regbank_properties.sv
// iosp_regbank_properties.sv: port checks on the low i/o register bank
// assumes: bound into iosp_regbank; one clock, sync reset
`timescale 1ns/100ps
`default_nettype none
module iosp_chk (
   input wire logic sys_clk_i,
   input wire logic srst_i,
   input wire logic [2:0] op_i,
   input wire logic [7:0] addr_i,
   input wire logic [2:0] bit_sel_i,
   input wire logic [7:0] wdata_i,
   input wire logic rvalid_o,
   input wire logic test_valid_o,
   input wire logic bad_access_o,
   input wire logic ext_sel_o,
   input wire logic [7:0] flag_set_i,
   input wire logic [7:0] flag_o,
   input wire logic [47:0] pin_out_o,
   input wire logic [47:0] pin_oe_o
);
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (srst_i);
   chk_read_answer: assert property ((op_i == 3'h1 && addr_i <= 8'h3F) |=> rvalid_o)
      else $error("read not answered");
   chk_port_refuse: assert property ((op_i inside {3'h1, 3'h2} && addr_i > 8'h3F)
      |=> bad_access_o && $stable(pin_oe_o)) else $error("port op not refused");
   chk_ds_alias: assert property ((op_i == 3'h4 && addr_i == 8'h31)
      |=> pin_out_o[47:40] == $past(wdata_i)) else $error("alias wrong");
   chk_ext_decode: assert property (
      ext_sel_o == (op_i inside {3'h3, 3'h4} && addr_i >= 8'h60)) else $error("ext select wrong");
   chk_bit_refuse: assert property ((op_i inside {3'h5, 3'h6} && addr_i > 8'h1F)
      |=> bad_access_o && $stable(pin_out_o)) else $error("bit op not refused");
   chk_test_answer: assert property (op_i == 3'h7 |=> test_valid_o)
      else $error("bit test not answered");
   chk_flag_clear: assert property ((op_i == 3'h2 && addr_i == 8'h12 && flag_set_i == 8'h0)
      |=> flag_o == ($past(flag_o) & ~$past(wdata_i))) else $error("flag clear wrong");
   chk_bit_only: assert property ((op_i == 3'h5 && addr_i == 8'h02)
      |=> pin_out_o[7:0] == ($past(pin_out_o[7:0]) | 8'h01 << $past(bit_sel_i)))
      else $error("bit set spread");
endmodule // iosp_chk
bind iosp_regbank iosp_chk u_chk (.sys_clk_i(sys_clk_i), .srst_i(srst_i), .op_i(op_i),
   .addr_i(addr_i), .bit_sel_i(bit_sel_i), .wdata_i(wdata_i), .rvalid_o(rvalid_o),
   .test_valid_o(test_valid_o), .bad_access_o(bad_access_o), .ext_sel_o(ext_sel_o),
   .flag_set_i(flag_set_i), .flag_o(flag_o), .pin_out_o(pin_out_o), .pin_oe_o(pin_oe_o));
`default_nettype wire

// ===== verification/testbench.sv
// testbench.sv: self-checking bench for the low i/o register bank
// assumes: bank, checker and extended space model compiled first
`timescale 1ns/100ps
`default_nettype none
module testbench;
   logic clk = 0, srst = 1, rv, tv, tb, bad, es, ew;
   logic [2:0] op = 0, bs = 0;
   logic [7:0] ad = 0, wd = 0, fs = 0, rd, ea, ewd, erd, fl, dir, outl, q [$];
   logic [47:0] pin = 0, po, poe;
   int n_fail = 0, compares = 0, cyc = 0;
   iosp_regbank uut (.sys_clk_i(clk), .srst_i(srst), .op_i(op), .addr_i(ad), .bit_sel_i(bs),
      .wdata_i(wd), .rdata_o(rd), .rvalid_o(rv), .test_bit_o(tb), .test_valid_o(tv),
      .bad_access_o(bad), .ext_sel_o(es), .ext_wr_o(ew), .ext_addr_o(ea), .ext_wdata_o(ewd),
      .ext_rdata_i(erd), .flag_set_i(fs), .flag_o(fl), .pin_in_i(pin), .pin_out_o(po),
      .pin_oe_o(poe));
   iosp_ext_model u_ext (.sys_clk_i(clk), .sel_i(es), .wr_i(ew), .addr_i(ea), .wdata_i(ewd),
      .rdata_o(erd));
   initial forever #5 clk = ~clk;
   task automatic check(input logic [7:0] s, e);
      compares++;
      if (s !== e) begin
         n_fail++;
         $display("mismatch %0t: got %h want %h", $time, s, e);
      end
   endtask
   task automatic summarize;
      if (n_fail == 0 && compares > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // one access a cycle; reads and bit tests leave a note
   task automatic acc(input logic [2:0] o, input logic [7:0] a, w, e = 8'h0,
         input logic [2:0] b = 3'h0, input logic [7:0] f = 8'h0);
      @(posedge clk);
      {op, ad, wd, bs, fs} <= {o, a, w, b, f};
      if (o inside {3'h1, 3'h3, 3'h7}) q.push_back(e);
   endtask
   // answers come in issue order, so the oldest note is due
   always @(posedge clk) begin
      if (rv) check(rd, q.pop_front());
      if (tv) check({7'h0, tb}, q.pop_front());
      if (++cyc > 1000) begin
         n_fail++;
         summarize();
      end
   end
   initial begin
      void'($urandom(32'h2790));
      pin <= 48'({$urandom, $urandom});
      repeat (2) @(posedge clk);
      srst <= 1'b0;
      acc(3'h3, 8'h21, 8'h0, 8'h0);
      // writes hit mapped registers except the ~dir write above 0x3F, which is refused; no bit is reserved
      // pins held long before reads, past the two-stage synchroniser
      for (int p = 0; p < 6; p++) begin
         dir = 8'($urandom);
         outl = 8'($urandom);
         acc(3'h2, 8'(3 * p + 1), dir);
         acc(3'h4, 8'(3 * p + 34), outl);
         acc(3'h2, 8'(3 * p), 8'hA5);
         acc(3'h2, 8'(3 * p + 65), ~dir);
         acc(3'h1, 8'(3 * p + 1), 8'h0, dir);
         acc(3'h3, 8'(3 * p + 34), 8'h0, outl);
         acc(3'h1, 8'(3 * p), 8'h0, pin[8 * p +: 8]);
         check(poe[8 * p +: 8], dir);
      end
      for (int b = 0; b < 8; b++) begin
         acc(3'h5, 8'h02, 8'h0, 8'h0, 3'(b));
         acc(3'h7, 8'h02, 8'h0, 8'h01, 3'(b));
         acc(3'h6, 8'h05, 8'h0, 8'h0, 3'(b));
      end
      acc(3'h6, 8'h22, 8'h0);
      acc(3'h7, 8'h20, 8'h0);
      check(po[7:0], 8'hFF);
      check(po[15:8], 8'h00);
      acc(3'h0, 8'h0, 8'h0, 8'h0, 3'h0, 8'h5A);
      acc(3'h3, 8'h32, 8'h0, 8'h5A);
      acc(3'h2, 8'h12, 8'h12);
      acc(3'h6, 8'h12, 8'h0, 8'h0, 3'h3);
      acc(3'h5, 8'h12, 8'h0, 8'h0, 3'h6);
      acc(3'h7, 8'h12, 8'h0, 8'h01, 3'h3);
      acc(3'h1, 8'h12, 8'h0, 8'h08);
      acc(3'h4, 8'h60, 8'h3C);
      acc(3'h4, 8'hFF, 8'hC3);
      acc(3'h2, 8'h60, 8'h0);
      acc(3'h3, 8'h60, 8'h0, 8'h3C);
      acc(3'h3, 8'hFF, 8'h0, 8'hC3);
      acc(3'h3, 8'h5F, 8'h0, 8'h0);
      repeat (3) acc(3'h0, 8'h0, 8'h0);
      check(8'(q.size()), 8'h00);
      summarize();
   end
endmodule // testbench
`default_nettype wire
